// ### design/icsa_pkg.sv
// Shared constants for the interval counter with serial assist
package icsa_pkg;
  // Register byte addresses
  localparam logic [3:0] ICSA_ADDR_CTRL = 4'h0;
  localparam logic [3:0] ICSA_ADDR_PRELOAD = 4'h4;
  localparam logic [3:0] ICSA_ADDR_COUNT = 4'h8;
  localparam logic [3:0] ICSA_ADDR_STATUS = 4'hc;
  // Control field positions
  localparam int ICSA_CTRL_SEL_LO = 0;
  localparam int ICSA_CTRL_EN = 2;
  localparam int ICSA_CTRL_START = 3;
  localparam int ICSA_CTRL_TXBIT = 4;
  localparam int ICSA_CTRL_LOAD = 5;
  // Status field positions
  localparam int ICSA_STAT_RX = 0;
  localparam int ICSA_STAT_TX = 1;
  localparam int ICSA_STAT_WAIT = 2;
  localparam int ICSA_STAT_FIFO_LO = 8;
  // Reset values
  localparam logic [7:0] ICSA_CTRL_RST = 8'h00;
  localparam logic [7:0] ICSA_PRELOAD_RST = 8'h00;
  localparam logic [7:0] ICSA_COUNT_RST = 8'h00;
  // Clock sources
  typedef enum logic [1:0] {
    ICSA_SRC_MCLK = 2'b00,
    ICSA_SRC_ACLK = 2'b01,
    ICSA_SRC_PIN = 2'b10,
    ICSA_SRC_AND = 2'b11
  } icsa_src_e;
  // Start-bit detector states
  typedef enum logic [1:0] {
    ICSA_ST_RUN = 2'b00,
    ICSA_ST_WAIT = 2'b01,
    ICSA_ST_FIRST = 2'b10
  } icsa_state_e;
  // Sample FIFO size
  localparam int ICSA_FIFO_DEPTH = 32;
  localparam int ICSA_FIFO_WIDTH = 1;
endpackage

// ### design/icsa_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module icsa_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign level_o = cnt_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### design/icsa_top.sv
// Eight-bit interval counter with start-bit detection and serial bit latches
// Overview of operation
// - An eight-bit up-counter is paired with an eight-bit pre-load register.
// - A two-bit field picks the count clock: master, auxiliary, pin bit one, or master AND pin.
// - Asserting the load control copies the pre-load register into the counter.
// - A software write to the counter address loads the counter from the pre-load register.
// - The pre-load register is read/write and may be rewritten once a load has finished.
// - With enable high the counter steps by one per rising edge of the chosen clock and reloads the pre-load value after 8'hff, else holds.
// - With start detection on, the counter idles until a start edge appears on receive input.
// - After a start edge the receive level is sampled when the first interval completes.
// - Receive and transmit latches are both clocked by the counter carry-out.
// - Software supplies one transmit bit at a time; each is driven out at carry-out timing while start detection is off.
// - Port bit one supplies the external clock and port bit two carries serial data.
`timescale 1ns/1ps
module icsa_top
  import icsa_pkg::*;
#(
  parameter int FIFO_DEPTH = ICSA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock sources, sampled as levels
  input wire logic mclk_i,
  input wire logic aclk_i,
  // Port pins shared with the counter
  input wire logic port0_bit_one_i,
  input wire logic port0_bit_two_i,
  output logic port0_bit_two_o,
  output logic port0_bit_two_oe_o,
  // Receive latch and carry pulse
  output logic receive_sample_latch_o,
  output logic carry_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_reg;
  logic [7:0] preload_reg;
  logic [7:0] count_reg;
  logic receive_sample_latch;
  logic transmit_output_latch;
  logic clk_src;
  logic clk_src_d_reg;
  logic tick;
  logic carry;
  logic load_req;
  logic rx_d_reg;
  logic start_edge;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_pop;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [31:0] rd_data;
  icsa_state_e state_reg;
  logic ctrl_wr;
  logic count_wr;
  logic preload_wr;
  logic fifo_push;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: one ack per request, dropped the cycle after
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Registers are eight bits wide, so a write needs byte lane zero
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_rd = wb_req && !wb_we_i;
  assign ctrl_wr = wb_wr && (wb_adr_i == ICSA_ADDR_CTRL);
  assign count_wr = wb_wr && (wb_adr_i == ICSA_ADDR_COUNT);
  assign preload_wr = wb_wr && (wb_adr_i == ICSA_ADDR_PRELOAD);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ICSA_ADDR_CTRL: rd_data[7:0] = ctrl_reg;
      ICSA_ADDR_PRELOAD: rd_data[7:0] = preload_reg;
      ICSA_ADDR_COUNT: rd_data[7:0] = count_reg;
      ICSA_ADDR_STATUS: begin
        rd_data[ICSA_STAT_RX] = receive_sample_latch;
        rd_data[ICSA_STAT_TX] = transmit_output_latch;
        rd_data[ICSA_STAT_WAIT] = (state_reg == ICSA_ST_WAIT);
        rd_data[ICSA_STAT_FIFO_LO +: 8] = 8'(fifo_level);
        rd_data[ICSA_STAT_FIFO_LO + 8] = fifo_out_valid;
        rd_data[ICSA_STAT_FIFO_LO + 9] = fifo_out_valid && fifo_out_data;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_rd) begin
      wb_dat_o <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and pre-load registers; load bit self-clears
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= ICSA_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= wb_dat_i[7:0] & ~(8'h01 << ICSA_CTRL_LOAD);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      preload_reg <= ICSA_PRELOAD_RST;
    end else if (preload_wr) begin
      preload_reg <= wb_dat_i[7:0];
    end
  end

  // Load from control bit or from a write at the counter address
  assign load_req = count_wr
    || (ctrl_wr && wb_dat_i[ICSA_CTRL_LOAD]);

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection; edges found by sampling, so sources must be slower than ref_clk
  always_comb begin
    case (icsa_src_e'(ctrl_reg[ICSA_CTRL_SEL_LO +: 2]))
      ICSA_SRC_MCLK: clk_src = mclk_i;
      ICSA_SRC_ACLK: clk_src = aclk_i;
      ICSA_SRC_PIN: clk_src = port0_bit_one_i;
      ICSA_SRC_AND: clk_src = mclk_i & port0_bit_one_i;
      default: clk_src = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      clk_src_d_reg <= 1'b0;
    end else begin
      clk_src_d_reg <= clk_src;
    end
  end

  // Starts at the idle line level, so no false start edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rx_d_reg <= 1'b1;
    end else begin
      rx_d_reg <= port0_bit_two_i;
    end
  end

  assign tick = clk_src && !clk_src_d_reg;
  // Start bit is a falling edge on the receive pin
  assign start_edge = rx_d_reg && !port0_bit_two_i;

  ////////////////////////////////////////////////////////////////////////////
  // Start-bit detection; each control write with the start bit set re-arms the wait,
  // decoded from the write data so the arming write itself takes effect
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ICSA_ST_RUN;
    end else if (ctrl_wr) begin
      if (wb_dat_i[ICSA_CTRL_START]) begin
        state_reg <= ICSA_ST_WAIT;
      end else begin
        state_reg <= ICSA_ST_RUN;
      end
    end else if (!ctrl_reg[ICSA_CTRL_START]) begin
      state_reg <= ICSA_ST_RUN;
    end else begin
      case (state_reg)
        ICSA_ST_RUN: begin
          state_reg <= ICSA_ST_RUN;
        end
        ICSA_ST_WAIT: begin
          if (start_edge) begin
            state_reg <= ICSA_ST_FIRST;
          end
        end
        ICSA_ST_FIRST: begin
          if (carry) begin
            state_reg <= ICSA_ST_RUN;
          end
        end
        default: state_reg <= ICSA_ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  // Waiting for a start edge parks the counter on the pre-load value
  assign carry = tick && ctrl_reg[ICSA_CTRL_EN] && (state_reg != ICSA_ST_WAIT)
    && (count_reg == 8'hff);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      count_reg <= ICSA_COUNT_RST;
    end else if (load_req) begin
      count_reg <= preload_reg;
    end else if (state_reg == ICSA_ST_WAIT) begin
      count_reg <= preload_reg;
    end else if (tick && ctrl_reg[ICSA_CTRL_EN]) begin
      if (count_reg == 8'hff) begin
        count_reg <= preload_reg;
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial latches on carry-out
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      carry_o <= 1'b0;
    end else begin
      carry_o <= carry;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      receive_sample_latch <= 1'b1;
    end else if (carry) begin
      receive_sample_latch <= port0_bit_two_i;
    end
  end

  // Software must set the next transmit bit before the carry that sends it
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      transmit_output_latch <= 1'b1;
    end else if (carry) begin
      transmit_output_latch <= ctrl_reg[ICSA_CTRL_TXBIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      port0_bit_two_o <= 1'b1;
    end else begin
      port0_bit_two_o <= transmit_output_latch;
    end
  end

  // Pin two drives transmit data unless start detection is using it as input
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      port0_bit_two_oe_o <= 1'b0;
    end else begin
      port0_bit_two_oe_o <= !ctrl_reg[ICSA_CTRL_START];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      receive_sample_latch_o <= 1'b1;
    end else begin
      receive_sample_latch_o <= receive_sample_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received samples queue; a read of status pops one. Full FIFO drops new samples.
  assign fifo_pop = wb_rd && wb_adr_i == ICSA_ADDR_STATUS;
  // Samples are queued only while start detection is on
  assign fifo_push = carry && ctrl_reg[ICSA_CTRL_START];

  icsa_fifo #(
    .WIDTH(ICSA_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(port0_bit_two_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  logic fifo_unused;
  assign fifo_unused = fifo_in_ready;
endmodule

// ### verification/icsa_checker.sv
// Pin-level assertions for the interval counter top
`timescale 1ns/1ps
module icsa_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sources and pins
  input wire logic mclk_i,
  input wire logic aclk_i,
  input wire logic port0_bit_one_i,
  input wire logic port0_bit_two_o,
  input wire logic receive_sample_latch_o,
  input wire logic carry_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack unasked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved");
  carry_pulse_a: assert property (carry_o |=> !carry_o)
    else $error("carry too long");
  tx_timing_a: assert property ($changed(port0_bit_two_o) |-> carry_o || $past(carry_o))
    else $error("tx off carry");
  rx_timing_a: assert property ($changed(receive_sample_latch_o) |-> carry_o || $past(carry_o))
    else $error("rx off carry");
  carry_idle_a: assert property ((!mclk_i && !aclk_i && !port0_bit_one_i) [*8] |-> !carry_o)
    else $error("carry with sources stopped");
  cover property (wb_ack_o && wb_we_i);
  cover property (carry_o);
  cover property ($changed(receive_sample_latch_o));
endmodule
////////////////////
bind icsa_top icsa_checker u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mclk_i(mclk_i), .aclk_i(aclk_i), .port0_bit_one_i(port0_bit_one_i),
  .port0_bit_two_o(port0_bit_two_o), .receive_sample_latch_o(receive_sample_latch_o),
  .carry_o(carry_o));

// ### verification/icsa_partner.sv
// Far side: pulse source on pin one, serial sender on pin two
`timescale 1ns/1ps
module icsa_partner #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic clk_i,
  // Bench control
  input wire logic pulse_en_i,
  input wire logic pin_hold_i,
  input wire logic rx_level_i,
  // Lines toward the device
  output logic pin_one_o = 1'b0,
  output logic rx_line_o = 1'b1
);
  int cnt = 0;
  logic tog = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      tog <= ~tog;
    end
    pin_one_o <= pulse_en_i ? tog : pin_hold_i;
    rx_line_o <= rx_level_i;
  end
endmodule

// ### verification/icsa_top_tb.sv
// Random and corner-case bench for the interval counter top
`timescale 1ns/1ps
module icsa_top_tb;
  import icsa_pkg::*;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic run = 1'b1, mclk = 1'b0, aclk = 1'b0, pulse_en = 1'b1, pin_hold = 1'b1;
  logic rx_level = 1'b1, ack, pin_o, oe, rx_latch, carry, pin_one, rx_line, pin_two, b;
  logic [3:0] adr = 4'h0, sel = 4'hf, cnt = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [7:0] p;
  int error_cnt = 0, checked = 0, gap;
  int per [4] = '{4, 16, 6, 4};
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cnt <= cnt + 4'h1;
    mclk <= run & cnt[1];
    aclk <= run & cnt[3];
  end
  // Shared pin two: the device drives while enabled, else the far side
  assign pin_two = oe ? pin_o : rx_line;
  icsa_top u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mclk_i(mclk), .aclk_i(aclk), .port0_bit_one_i(pin_one),
    .port0_bit_two_i(pin_two), .port0_bit_two_o(pin_o), .port0_bit_two_oe_o(oe),
    .receive_sample_latch_o(rx_latch), .carry_o(carry));
  icsa_partner #(.HALF(3)) u_far (.clk_i(ref_clk_i), .pulse_en_i(pulse_en),
    .pin_hold_i(pin_hold), .rx_level_i(rx_level), .pin_one_o(pin_one), .rx_line_o(rx_line));
  ////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 1, 0);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge ref_clk_i);
  endtask
  task automatic wait_carry();
    gap = 0;
    do begin
      @(posedge ref_clk_i);
      gap++;
    end while (carry !== 1'b1 && gap < 5000);
    if (gap >= 5000) chk("carry", 1, 0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  ////////////////////
  initial begin
    void'($urandom(26));
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("rx reset", 1, rx_latch);
    foreach (per[i]) begin
      wb(0, 4'(i * 4 + (i == 3 ? -10 : 0)), 0);
      chk("reset read", 0, q);
    end
    p = 8'($urandom);
    wb(1, ICSA_ADDR_PRELOAD, {24'h0, p});
    sel <= 4'he;
    wb(1, ICSA_ADDR_PRELOAD, {24'h0, ~p});
    sel <= 4'hf;
    wb(1, ICSA_ADDR_COUNT, $urandom);
    wb(1, ICSA_ADDR_PRELOAD, {24'h0, ~p});
    wb(0, ICSA_ADDR_COUNT, 0);
    chk("count load", {24'h0, p}, q);
    wb(0, ICSA_ADDR_PRELOAD, 0);
    chk("preload", {24'h0, ~p}, q);
    wb(1, ICSA_ADDR_CTRL, 32'h20);
    wb(0, ICSA_ADDR_COUNT, 0);
    chk("ctrl load", {24'h0, ~p}, q);
    for (int s = 0; s < 4; s++) begin
      p = 8'hf0 + 8'($urandom_range(12));
      b = 1'($urandom);
      pulse_en <= (s != 3);
      wb(1, ICSA_ADDR_PRELOAD, {24'h0, p});
      wb(1, ICSA_ADDR_COUNT, 0);
      wb(1, ICSA_ADDR_CTRL, {27'h0, b, 2'b01, 2'(s)});
      wait_carry();
      wait_carry();
      chk("interval", (256 - p) * per[s], gap);
      repeat (2) @(posedge ref_clk_i);
      chk("tx pin", b, pin_two);
    end
    wb(1, ICSA_ADDR_CTRL, 0);
    wb(1, ICSA_ADDR_COUNT, 0);
    repeat (30) @(posedge ref_clk_i);
    wb(0, ICSA_ADDR_COUNT, 0);
    chk("hold", {24'h0, p}, q);
    wb(1, ICSA_ADDR_PRELOAD, 32'hfe);
    wb(1, ICSA_ADDR_CTRL, 32'h0c);
    wb(0, ICSA_ADDR_STATUS, 0);
    chk("waiting", 1, q[2]);
    chk("pin released", 0, oe);
    gap = 0;
    repeat (60) begin
      @(posedge ref_clk_i);
      if (carry === 1'b1) gap++;
    end
    chk("idle carries", 0, gap);
    rx_level <= 1'b0;
    wait_carry();
    repeat (2) @(posedge ref_clk_i);
    chk("rx sample", 0, rx_latch);
    rx_level <= 1'b1;
    repeat (40) wait_carry();
    wb(1, ICSA_ADDR_CTRL, 0);
    for (int i = 0; i <= 32; i++) begin
      wb(0, ICSA_ADDR_STATUS, 0);
      chk("fifo level", 32 - i, q[15:8]);
      chk("fifo valid", i < 32, q[16]);
      if (i < 32) chk("fifo head", i != 0, q[17]);
    end
    {run, pulse_en, pin_hold} <= 3'b000;
    repeat (20) @(posedge ref_clk_i);
    finish_test();
  end
endmodule
